// file: design/cdfc_cfg.svh
// cdfc_cfg.svh: timing and field constants for the chopper decay and fault control block
// assumes a 10 mhz pclk; the off-time and blanking counts derive from the times below, the toff reset value is a literal
`ifndef CDFC_CFG_SVH
`define CDFC_CFG_SVH
`define CDFC_CLK_HZ 10000000
`define CDFC_TOFF_US 30
`define CDFC_TBLANK_US 1
`define CDFC_TOFF_CYC ((`CDFC_TOFF_US * `CDFC_CLK_HZ) / 1000000)
`define CDFC_TBLANK_CYC (((`CDFC_TBLANK_US * `CDFC_CLK_HZ) + 999999) / 1000000)
`define CDFC_FAST_NUM 5
`define CDFC_FAST_DEN 16
`define CDFC_RES_FULL 2'h0
`define CDFC_REG_CTRL 12'h000
`define CDFC_REG_STAT 12'h004
`define CDFC_REG_TOFF 12'h008
`define CDFC_REG_DAC 12'h00c
`define CDFC_CTRL_RST 32'h0000_0000
`define CDFC_TOFF_RST 16'h012c
`endif

// file: design/cdfc_pkg.sv
// cdfc_pkg: types for the chopper decay and fault control block
// assumes cdfc_cfg.svh supplies the numeric constants
package cdfc_pkg;
  typedef enum logic [1:0] {CDFC_OSC_HIGH, CDFC_OSC_GND, CDFC_OSC_RES} cdfc_osc_t;
  typedef enum logic {CDFC_SLOW, CDFC_MIXED} cdfc_decay_t;
  typedef enum logic [1:0] {CDFC_ON, CDFC_FAST, CDFC_SLOWD} cdfc_phase_t;
  // gate drive of one full bridge
  typedef struct packed {
    logic src_a;
    logic snk_a;
    logic src_b;
    logic snk_b;
  } cdfc_gate_t;
  typedef struct packed {
    logic thermal_trip;
    logic pump_uv;
    logic regulator_fault;
    logic supply_lockout;
  } cdfc_fault_t;
endpackage

// file: design/cdfc_chopper.sv
// cdfc_chopper: off-time chopper, decay sequencing, output gating and faults for two windings
// assumes comparator, fault and pin levels arrive asynchronously and are resynchronised here
//
// Chosen here: register access over APB and the placing of the registers.
module cdfc_chopper import cdfc_pkg::*; #(
  parameter int TW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_n,
  input wire logic sleep_n,
  input wire logic reset_n,
  input wire logic [1:0] off_time_select_pin,
  input wire logic resolution_select_lo,
  input wire logic resolution_select_hi,
  input wire logic [1:0] trip_raw,
  input wire logic [1:0] short_gnd_raw,
  input wire logic [1:0] zero_cur_raw,
  input wire logic [3:0] fault_raw,
  input wire logic [1:0] dac_fall,
  input wire logic [1:0] polarity,
  output cdfc_gate_t [1:0] gate,
  output logic [1:0] pump_run,
  output logic translator_home
);
`include "cdfc_cfg.svh"
  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  localparam int NS = 17;
  logic [NS-1:0] s1, s2;
  wire [NS-1:0] raw_in = {enable_n, sleep_n, reset_n, off_time_select_pin,
    resolution_select_lo, resolution_select_hi, trip_raw, short_gnd_raw,
    zero_cur_raw, fault_raw};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw_in;
      s2 <= s1;
    end
  end
  wire en_n_s = s2[16];
  wire sleep_s = s2[15];
  wire rst_s = s2[14];
  wire [1:0] osc_s = s2[13:12];
  wire [1:0] res_s = s2[11:10];
  wire [1:0] trip_s = s2[9:8];
  wire [1:0] sgnd_s = s2[7:6];
  wire [1:0] zero_s = s2[5:4];
  cdfc_fault_t flt;
  assign flt = cdfc_fault_t'(s2[3:0]);

  // -------------------------------------------------------------
  // apb registers
  // -------------------------------------------------------------
  logic [31:0] ctrl;
  logic [TW-1:0] toff_res;
  wire wr = psel && penable && pwrite;
  wire hit_ctrl = paddr == `CDFC_REG_CTRL;
  wire hit_stat = paddr == `CDFC_REG_STAT;
  wire hit_toff = paddr == `CDFC_REG_TOFF;
  wire hit_dac = paddr == `CDFC_REG_DAC;
  wire mapped = hit_ctrl || hit_stat || hit_toff || hit_dac;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // one element per bridge; short_lat, decay and phase written by the bridge's own process, dac_pct by the apb process
  logic short_lat [2];
  cdfc_decay_t decay [2];
  cdfc_phase_t phase [2];
  logic [6:0] dac_pct [2];
  wire osc_res = osc_s == 2'(CDFC_OSC_RES);
  // 30us is fixed unless the select pin sees a resistor; then software loads the count
  wire [TW-1:0] toff_cyc = osc_res ? toff_res : TW'(`CDFC_TOFF_CYC);
  wire [TW-1:0] fast_cyc = TW'((32'(toff_cyc) * `CDFC_FAST_NUM) / `CDFC_FAST_DEN);
  wire [31:0] stat = {20'h0, flt, short_lat[1], short_lat[0], 2'h0, decay[1], decay[0],
    phase[1] != CDFC_ON, phase[0] != CDFC_ON};
  wire [31:0] rd_dac = {17'h0, dac_pct[1], 1'b0, dac_pct[0]};
  wire [31:0] rd_mux = hit_ctrl ? ctrl :
    hit_stat ? stat :
    hit_toff ? 32'(toff_res) :
    hit_dac ? rd_dac :
    32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CDFC_CTRL_RST;
      toff_res <= TW'(`CDFC_TOFF_RST);
      dac_pct[0] <= '0;
      dac_pct[1] <= '0;
      prdata <= '0;
    end else begin
      if (wr && hit_ctrl) ctrl <= pwdata;
      if (wr && hit_toff) toff_res <= pwdata[TW-1:0];
      if (wr && hit_dac) begin
        dac_pct[0] <= pwdata[6:0];
        dac_pct[1] <= pwdata[14:8];
      end
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // -------------------------------------------------------------
  // disable causes
  // -------------------------------------------------------------
  wire global_off = en_n_s || !sleep_s || !rst_s || flt.regulator_fault || flt.thermal_trip ||
    flt.pump_uv || flt.supply_lockout;
  wire home = !sleep_s || !rst_s || flt.supply_lockout || flt.thermal_trip;
  assign translator_home = home;
  assign pump_run = {2{sleep_s}};

  // -------------------------------------------------------------
  // gate decode
  // -------------------------------------------------------------
  // polarity picks the diagonal; fast decay reverses it, slow decay shorts through sinks;
  // the rectifying fets drop out near zero current so the winding never reverses
  function automatic cdfc_gate_t gate_f(input cdfc_phase_t ph, input logic pol,
    input logic rect);
    cdfc_gate_t drv;
    cdfc_gate_t rev;
    drv = pol ? cdfc_gate_t'(4'b1001) : cdfc_gate_t'(4'b0110);
    rev = pol ? cdfc_gate_t'(4'b0110) : cdfc_gate_t'(4'b1001);
    case (ph)
      CDFC_ON: gate_f = drv;
      CDFC_FAST: gate_f = rect ? rev : cdfc_gate_t'(4'b0000);
      CDFC_SLOWD: gate_f = rect ? cdfc_gate_t'(4'b0101) : cdfc_gate_t'(4'b0000);
      default: gate_f = cdfc_gate_t'(4'b0000);
    endcase
  endfunction

  // -------------------------------------------------------------
  // per-bridge chopper
  // -------------------------------------------------------------
  logic [TW-1:0] tcnt [2];
  logic [7:0] bcnt [2];
  for (genvar i = 0; i < 2; i++) begin : g_br
    wire full = res_s == `CDFC_RES_FULL;
    wire want_mixed = osc_res ? dac_fall[i] : full ? 1'b0 :
      (osc_s == 2'(CDFC_OSC_GND)) ? 1'b1 : dac_fall[i];
    wire blanked = bcnt[i] != '0;
    wire trip = trip_s[i] && !blanked && phase[i] == CDFC_ON;
    wire off_done = tcnt[i] == toff_cyc - TW'(1);
    wire fast_done = tcnt[i] == fast_cyc;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        phase[i] <= CDFC_ON;
        tcnt[i] <= '0;
        bcnt[i] <= '0;
        decay[i] <= CDFC_MIXED;
        short_lat[i] <= 1'b0;
      end else begin
        if (!sleep_s) short_lat[i] <= 1'b0;
        else if (sgnd_s[i]) short_lat[i] <= 1'b1;
        if (home) decay[i] <= CDFC_MIXED;
        else decay[i] <= want_mixed ? CDFC_MIXED : CDFC_SLOW;
        if (global_off || short_lat[i]) begin
          phase[i] <= CDFC_ON;
          tcnt[i] <= '0;
          bcnt[i] <= 8'(`CDFC_TBLANK_CYC);
        end else begin
          case (phase[i])
            CDFC_ON: begin
              if (blanked) bcnt[i] <= bcnt[i] - 8'h01;
              if (trip) begin
                tcnt[i] <= '0;
                phase[i] <= (decay[i] == CDFC_MIXED) ? CDFC_FAST : CDFC_SLOWD;
              end
            end
            CDFC_FAST: begin
              tcnt[i] <= tcnt[i] + TW'(1);
              if (fast_done) phase[i] <= CDFC_SLOWD;
            end
            CDFC_SLOWD: begin
              tcnt[i] <= tcnt[i] + TW'(1);
              if (off_done) begin
                phase[i] <= CDFC_ON;
                bcnt[i] <= 8'(`CDFC_TBLANK_CYC);
              end
            end
            default: phase[i] <= CDFC_ON;
          endcase
        end
      end
    end
    wire rect = !zero_s[i];
    cdfc_gate_t g;
    assign g = gate_f(phase[i], polarity[i], rect);
    assign gate[i] = (global_off || short_lat[i]) ? '0 : g;

    a_rect_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (phase[i] != CDFC_ON && zero_s[i]) |-> gate[i] == '0)
      else $error("rectifying fets on at zero current");
    a_slow_recirc: assert property (@(posedge pclk) disable iff (!presetn)
      (phase[i] == CDFC_SLOWD && !zero_s[i] && !global_off && !short_lat[i])
      |-> gate[i] == cdfc_gate_t'(4'b0101))
      else $error("slow decay sinks not on");
    a_decay_home: assert property (@(posedge pclk) disable iff (!presetn)
      home |=> decay[i] == CDFC_MIXED)
      else $error("decay not mixed at home");
    a_high_slow: assert property (@(posedge pclk) disable iff (!presetn)
      (!home && osc_s == 2'(CDFC_OSC_HIGH) && (full || !dac_fall[i])) |=> decay[i] == CDFC_SLOW)
      else $error("tied high did not pick slow");
    a_high_fall: assert property (@(posedge pclk) disable iff (!presetn)
      (!home && osc_s == 2'(CDFC_OSC_HIGH) && !full && dac_fall[i]) |=> decay[i] == CDFC_MIXED)
      else $error("falling step not mixed");
    a_gnd_mixed: assert property (@(posedge pclk) disable iff (!presetn)
      (!home && osc_s == 2'(CDFC_OSC_GND) && !full) |=> decay[i] == CDFC_MIXED)
      else $error("grounded select not mixed");
    a_gnd_full: assert property (@(posedge pclk) disable iff (!presetn)
      (!home && osc_s == 2'(CDFC_OSC_GND) && full) |=> decay[i] == CDFC_SLOW)
      else $error("grounded full step not slow");
    a_res_fall: assert property (@(posedge pclk) disable iff (!presetn)
      (!home && osc_res && dac_fall[i]) |=> decay[i] == CDFC_MIXED)
      else $error("resistor mode falling step not mixed");
    a_tcnt_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (trip && !global_off && !short_lat[i]) |=> tcnt[i] == '0)
      else $error("off-time count did not restart");
    a_blank_load: assert property (@(posedge pclk) disable iff (!presetn)
      (phase[i] == CDFC_SLOWD && off_done && !global_off && !short_lat[i])
      |=> bcnt[i] == 8'(`CDFC_TBLANK_CYC))
      else $error("blanking not restarted");

    a_blank_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (phase[i] == CDFC_ON && blanked) |-> ##1 phase[i] == CDFC_ON || global_off)
      else $error("trip accepted during blanking");
    a_fast_first: assert property (@(posedge pclk) disable iff (!presetn)
      (trip && decay[i] == CDFC_MIXED && !global_off && !short_lat[i]) |=> phase[i] == CDFC_FAST)
      else $error("mixed decay did not start fast");
    a_slow_only: assert property (@(posedge pclk) disable iff (!presetn)
      (trip && decay[i] == CDFC_SLOW && !global_off && !short_lat[i]) |=> phase[i] == CDFC_SLOWD)
      else $error("slow decay entered fast phase");
    a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (phase[i] == CDFC_ON && $past(phase[i]) != CDFC_ON && !global_off && !short_lat[i]
       && $past(!global_off && !short_lat[i])) |-> $past(tcnt[i]) == toff_cyc - TW'(1))
      else $error("off-time ended early");
    a_short_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (short_lat[i] && sleep_s) |=> short_lat[i])
      else $error("short latch released while awake");
    a_latched_off: assert property (@(posedge pclk) disable iff (!presetn)
      short_lat[i] |-> gate[i] == '0)
      else $error("latched bridge driven");
  end

  a_enable_off: assert property (@(posedge pclk) disable iff (!presetn)
    en_n_s |-> gate == '0)
    else $error("fets on while enable high");
  a_fault_off: assert property (@(posedge pclk) disable iff (!presetn)
    (flt.regulator_fault || flt.thermal_trip || flt.pump_uv) |-> gate == '0)
    else $error("fets on during fault");
  a_sleep_home: assert property (@(posedge pclk) disable iff (!presetn)
    !sleep_s |-> translator_home && pump_run == 2'h0 && gate == '0)
    else $error("sleep did not shut down");
  a_any_cause: assert property (@(posedge pclk) disable iff (!presetn)
    global_off |-> gate == '0)
    else $error("fets on with a disable cause");
  a_wake_pump: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_s |-> pump_run == 2'h3)
    else $error("pump stopped while awake");
  a_enable_seq: assert property (@(posedge pclk) disable iff (!presetn)
    (en_n_s && sleep_s && rst_s && !flt.supply_lockout && !flt.thermal_trip)
    |-> !translator_home)
    else $error("enable alone homed translator");
  a_reset_home: assert property (@(posedge pclk) disable iff (!presetn)
    (!rst_s || flt.supply_lockout) |-> translator_home && gate == '0)
    else $error("reset did not home");
endmodule // cdfc_chopper

// file: verification/cdfc_bridge_model.sv
// cdfc_bridge_model: behavioural bridge, sense comparators and windings
// assumes the bench commands trips and shorts; the trip and short comparators only fire on a driven winding
module cdfc_bridge_model import cdfc_pkg::*; (
  input wire cdfc_gate_t [1:0] gate,
  input wire logic [1:0] trip_req,
  input wire logic [1:0] short_req,
  input wire logic [1:0] zero_req,
  output logic [1:0] trip_raw,
  output logic [1:0] short_gnd_raw,
  output logic [1:0] zero_cur_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [1:0] driven;
  // no source on means no current through the sense resistor, so no trip
  assign driven[0] = gate[0].src_a | gate[0].src_b;
  assign driven[1] = gate[1].src_a | gate[1].src_b;
  assign trip_raw = trip_req & driven;
  assign short_gnd_raw = short_req & driven;
  // recirculating current stays up through decay; the bench says when it has died out
  assign zero_cur_raw = zero_req;
endmodule // cdfc_bridge_model

// file: verification/tb_cdfc_chopper.sv
// tb_cdfc_chopper: self-checking bench for the chopper block
// assumes a 10 mhz pclk and the bridge model on the far side
module tb_cdfc_chopper;
  import cdfc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic en_n; logic sl_n; logic rs_n; logic [3:0] flt; logic off; logic home;
  } cdfc_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, enable_n = 0, sleep_n = 1, reset_n = 1, translator_home;
  logic [1:0] osel = 2'h1, trip_req = 0, short_req = 0, trip_raw, short_gnd_raw, zero_cur_raw;
  logic [1:0] pump_run, zero_req = 0, dac_fall = 0, res = 2'h1;
  logic [3:0] fault_raw = 0, g_on;
  cdfc_gate_t [1:0] gate;
  int errors = 0, n_checks = 0, n, nf;
  cdfc_row_t rows [8] = '{
    {3'b011, 4'h0, 2'b00}, {3'b111, 4'h0, 2'b10}, {3'b001, 4'h0, 2'b11},
    {3'b010, 4'h0, 2'b11}, {3'b011, 4'h2, 2'b10}, {3'b011, 4'h8, 2'b11},
    {3'b011, 4'h4, 2'b10}, {3'b011, 4'h1, 2'b11}};
  always #50 pclk = ~pclk;
  cdfc_chopper cdfc_chopper_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable_n(enable_n), .sleep_n(sleep_n), .reset_n(reset_n),
    .off_time_select_pin(osel), .resolution_select_lo(res[0]), .resolution_select_hi(res[1]),
    .trip_raw(trip_raw), .short_gnd_raw(short_gnd_raw), .zero_cur_raw(zero_cur_raw),
    .fault_raw(fault_raw), .dac_fall(dac_fall), .polarity(2'h0), .gate(gate),
    .pump_run(pump_run), .translator_home(translator_home));
  cdfc_bridge_model cdfc_bridge_model_i (.gate(gate), .trip_req(trip_req),
    .short_req(short_req), .zero_req(zero_req), .trip_raw(trip_raw), .short_gnd_raw(short_gnd_raw),
    .zero_cur_raw(zero_cur_raw));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // called just after a rising edge; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    if (k >= 50) begin errors++; finish_test; end
    @(posedge pclk);
  endtask
  // counts cycles while winding a shows value v, bounded
  task automatic hold(input logic [3:0] v, output int c);
    c = 0;
    while (gate[0] === v && c < 1000) begin cyc(1); c++; end
    if (c >= 1000) begin errors++; finish_test; end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(20);
    chk("gate_in_reset", 0, gate);
    chk("home_in_reset", 1, translator_home);
    @(posedge pclk) presetn <= 1;
    apb(0, 12'h008, 0);
    chk("toff_reset", 32'h0000012c, rd);
    apb(1, 12'h000, 32'h5a5a_00ff);
    apb(0, 12'h000, 0);
    chk("ctrl_rw", 32'h5a5a_00ff, rd);
    apb(1, 12'h010, 32'hffff_ffff);
    chk("unmapped_err", 1, er);
    apb(0, 12'h010, 0);
    chk("unmapped_rd", 0, rd);
    apb(1, 12'h00c, 32'h0000_3a15);
    apb(0, 12'h00c, 0);
    chk("dac_rw", 32'h0000_3a15, rd);
    foreach (rows[i]) begin
      @(posedge pclk);
      {enable_n, sleep_n, reset_n, fault_raw} <= {rows[i].en_n, rows[i].sl_n, rows[i].rs_n,
        rows[i].flt};
      cyc(6);
      chk("gate_off", rows[i].off, gate == 0);
      chk("pump_run", {2{rows[i].sl_n}}, pump_run);
      chk("home", rows[i].home, translator_home);
    end
    @(posedge pclk);
    {enable_n, sleep_n, reset_n, fault_raw} <= {3'b011, 4'h0};
    cyc(8);
    g_on = gate[0];
    chk("on_diagonal", 1, g_on == 4'b1001 || g_on == 4'b0110);
    @(posedge pclk) trip_req <= 2'b01;
    cyc(1);
    hold(g_on, n);
    hold(~g_on, nf);
    chk("fast_len", 1, nf >= 92 && nf <= 95);
    chk("slow_sinks", 4'b0101, gate[0]);
    hold(4'b0101, n);
    chk("off_len", 1, nf + n >= 299 && nf + n <= 302);
    chk("drive_back", g_on, gate[0]);
    hold(g_on, n);
    chk("blank_retrip", 1, n >= 10 && n <= 16);
    @(posedge pclk) trip_req <= 2'b00;
    cyc(320);
    @(posedge pclk) short_req <= 2'b01;
    cyc(6);
    @(posedge pclk) short_req <= 2'b00;
    cyc(6);
    chk("short_latched", 0, gate[0]);
    chk("other_bridge", 1, gate[1] != 0);
    apb(0, 12'h004, 0);
    chk("stat_short", 32'h0000_004c, rd);
    @(posedge pclk) sleep_n <= 0;
    cyc(6);
    @(posedge pclk) sleep_n <= 1;
    cyc(8);
    chk("short_cleared", 1, gate[0] != 0);
    cyc(10000);
    @(posedge pclk) trip_req <= 2'b01;
    cyc(1);
    hold(g_on, n);
    @(posedge pclk) zero_req <= 2'b01;
    cyc(4);
    chk("rect_off", 0, gate[0]);
    @(posedge pclk) {trip_req, zero_req} <= 4'h0;
    cyc(320);
    @(posedge pclk) osel <= 2'h0;
    cyc(4);
    @(posedge pclk) trip_req <= 2'b01;
    cyc(1);
    hold(g_on, n);
    chk("slow_direct", 4'b0101, gate[0]);
    hold(4'b0101, n);
    chk("slow_len", 1, n >= 299 && n <= 301);
    @(posedge pclk) trip_req <= 2'b00;
    cyc(20);
    @(posedge pclk) {dac_fall, trip_req} <= 4'h5;
    cyc(1);
    hold(g_on, n);
    chk("fall_mixed", 4'b1001, gate[0]);
    @(posedge pclk) {dac_fall, trip_req} <= 4'h0;
    cyc(320);
    apb(1, 12'h008, 32'h0000_0064);
    @(posedge pclk) osel <= 2'h2;
    cyc(4);
    @(posedge pclk) trip_req <= 2'b01;
    cyc(1);
    hold(g_on, n);
    chk("res_slow", 4'b0101, gate[0]);
    hold(4'b0101, n);
    chk("res_len", 1, n >= 99 && n <= 101);
    @(posedge pclk) trip_req <= 2'b00;
    cyc(20);
    @(posedge pclk) {osel, res} <= 4'h4;
    cyc(4);
    @(posedge pclk) trip_req <= 2'b01;
    cyc(1);
    hold(g_on, n);
    chk("full_slow", 4'b0101, gate[0]);
    @(posedge pclk) trip_req <= 2'b00;
    cyc(320);
    finish_test;
  end
endmodule // tb_cdfc_chopper
